/* File: asx_uart.sv */
// Asynchronous serial transmitter/receiver with one shared interrupt line.
// Assumes a synchronous serial input and a plain one-cycle register port.
//
// Summary of operation
// - three causes share one interrupt line
// - holding byte shifts out LSB first
// - empty flag set on load, irq if enabled
// - good frame copies word, sets full flag
// - receive flags update at last stop bit
// - overrun/framing error sets flag, no load
// - parity error flagged at stop bit
// - low start, data LSB first, high stops
// - modes 0, 1, 3 with 7..9 bits
// - mode 3 without parity uses ninth bits
// - 11 shift clocks of init after reset
// - two-bit level field, fixed vector pair
// - holding read clears full flag
// - error clears on status then holding read
// - holding write clears empty flag
// - parity select 0 odd, 1 even
`timescale 1ns/1ns
module asx_uart (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       ser_in_i,
  output logic            ser_out_o,
  output logic            serial_irq_line_o,
  output logic      [1:0] irq_level_o
);

  // ************************************************************
  // Registers and wires
  // ************************************************************
  logic [7:0]             mode_one_ff;
  logic [7:0]             rate_ff;
  logic [7:0]             mode_two_ff;
  logic [1:0]             irq_level_ff;
  logic                   rx_full_flag_ff;
  logic                   rx_error_flag_ff;
  logic                   tx_empty_flag_ff;
  logic                   err_armed_ff;
  logic                   tx_irq_enable_ff;
  logic                   rx_irq_enable_ff;
  logic                   tx_parity_or_ninth_ff;
  logic                   rx_parity_or_ninth_ff;
  logic [7:0]             tx_hold_ff;
  logic [7:0]             rx_hold_ff;
  logic [2:0]             evt_ff;
  logic [2:0]             evt_en_ff;
  logic [3:0]             init_cnt_ff;
  logic [7:0]             rdata_ff;
  logic                   irq_ff;
  asx_pkg::asx_tx_state_t tx_state_ff;
  logic [8:0]             tx_sh_ff;
  logic [3:0]             tx_cnt_ff;
  logic [2:0]             tx_os_ff;
  logic                   tx_par_ff;
  logic                   tx_stop_ff;
  logic                   ser_out_ff;
  asx_pkg::asx_rx_state_t rx_state_ff;
  logic [8:0]             rx_sh_ff;
  logic [3:0]             rx_cnt_ff;
  logic [2:0]             rx_os_ff;
  logic                   rx_stop_ff;
  logic                   rx_fe_ff;
  logic                   rx_perr_ff;

  logic [1:0] mode;
  logic       par_en;
  logic       two_stop;
  logic       ninth_en;
  logic       run;
  logic [3:0] data_len;
  logic       tick;
  logic       init_done;
  logic       wr_hold;
  logic       rd_hold;
  logic       rd_status;
  logic       tx_load;
  logic       rx_sample;
  logic       rx_done;
  logic       rx_bad;
  logic [8:0] rx_word;
  logic [7:0] tx_mask;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;

  // ************************************************************
  // Frame configuration
  // ************************************************************
  assign mode     = mode_one_ff[asx_pkg::MODE_ONE_MODE_LO +: 2];
  assign par_en   = mode_one_ff[asx_pkg::MODE_ONE_PAR_EN];
  assign two_stop = mode_one_ff[asx_pkg::MODE_ONE_TWO_STOP];
  assign run      = mode_two_ff[asx_pkg::MODE_TWO_RUN];
  assign ninth_en = (mode == asx_pkg::MODE3) && !par_en;
  // Unknown mode code 10 behaves as mode 1
  assign data_len = (mode == asx_pkg::MODE0) ? asx_pkg::LEN_MODE0 :
                    (ninth_en ? asx_pkg::LEN_NINTH : asx_pkg::LEN_MODE1);
  assign tx_mask  = (mode == asx_pkg::MODE0) ? 8'h7F : 8'hFF;

  assign wr_hold   = wr_i && (addr_i == asx_pkg::OFF_HOLD);
  assign rd_hold   = rd_i && (addr_i == asx_pkg::OFF_HOLD);
  assign rd_status = rd_i && (addr_i == asx_pkg::OFF_STATUS);

  // Divider keeps running until the current frames finish
  asx_tick_gen u_tick (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .run_i   (run || (tx_state_ff != asx_pkg::TX_IDLE) || (rx_state_ff != asx_pkg::RX_IDLE)),
    .div_i   (rate_ff),
    .tick_o  (tick)
  );

  // ************************************************************
  // Initialisation period
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      init_cnt_ff <= 4'h0;
    end else if (tick && !init_done) begin
      init_cnt_ff <= init_cnt_ff + 4'h1;
    end
  end
  assign init_done = (init_cnt_ff == asx_pkg::INIT_TICKS);

  // ************************************************************
  // Transmitter
  // ************************************************************
  // Load is held off during a holding write so no byte is lost
  assign tx_load = (tx_state_ff == asx_pkg::TX_IDLE) && !tx_empty_flag_ff && init_done && run && !wr_hold;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_state_ff <= asx_pkg::TX_IDLE;
      tx_sh_ff    <= 9'h000;
      tx_cnt_ff   <= 4'h0;
      tx_os_ff    <= 3'h0;
      tx_par_ff   <= 1'b0;
      tx_stop_ff  <= 1'b0;
      ser_out_ff  <= 1'b1;
    end else if (tx_state_ff == asx_pkg::TX_IDLE) begin
      if (tx_load) begin
        tx_state_ff <= asx_pkg::TX_START;
        tx_sh_ff    <= {tx_parity_or_ninth_ff, tx_hold_ff};
        tx_par_ff   <= ^(tx_hold_ff & tx_mask) ^ !tx_parity_or_ninth_ff;
        tx_os_ff    <= 3'h0;
        ser_out_ff  <= 1'b0;
      end
    end else if (tick) begin
      tx_os_ff <= tx_os_ff + 3'h1;
      if (tx_os_ff == asx_pkg::OS_LAST) begin
        unique case (tx_state_ff)
          asx_pkg::TX_START: begin
            tx_state_ff <= asx_pkg::TX_DATA;
            ser_out_ff  <= tx_sh_ff[0];
            tx_sh_ff    <= {1'b0, tx_sh_ff[8:1]};
            tx_cnt_ff   <= 4'h1;
          end
          asx_pkg::TX_DATA: begin
            if (tx_cnt_ff == data_len) begin
              tx_stop_ff <= 1'b0;
              if (par_en) begin
                tx_state_ff <= asx_pkg::TX_PAR;
                ser_out_ff  <= tx_par_ff;
              end else begin
                tx_state_ff <= asx_pkg::TX_STOP;
                ser_out_ff  <= 1'b1;
              end
            end else begin
              ser_out_ff <= tx_sh_ff[0];
              tx_sh_ff   <= {1'b0, tx_sh_ff[8:1]};
              tx_cnt_ff  <= tx_cnt_ff + 4'h1;
            end
          end
          asx_pkg::TX_PAR: begin
            tx_state_ff <= asx_pkg::TX_STOP;
            ser_out_ff  <= 1'b1;
          end
          asx_pkg::TX_STOP: begin
            if (two_stop && !tx_stop_ff) begin
              tx_stop_ff <= 1'b1;
            end else begin
              tx_state_ff <= asx_pkg::TX_IDLE;
            end
          end
          asx_pkg::TX_IDLE: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  assign rx_sample = tick && (rx_os_ff == asx_pkg::OS_MID) && (rx_state_ff != asx_pkg::RX_IDLE);
  assign rx_done   = rx_sample && (rx_state_ff == asx_pkg::RX_STOP) && (!two_stop || rx_stop_ff);
  // Overrun, framing and parity errors share one flag
  assign rx_bad    = rx_fe_ff || !ser_in_i || rx_perr_ff || rx_full_flag_ff;

  always_comb begin
    unique case (data_len)
      asx_pkg::LEN_MODE0: rx_word = {2'h0, rx_sh_ff[8:2]};
      asx_pkg::LEN_MODE1: rx_word = {1'b0, rx_sh_ff[8:1]};
      default:            rx_word = rx_sh_ff;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_state_ff <= asx_pkg::RX_IDLE;
      rx_sh_ff    <= 9'h000;
      rx_cnt_ff   <= 4'h0;
      rx_os_ff    <= 3'h0;
      rx_stop_ff  <= 1'b0;
      rx_fe_ff    <= 1'b0;
      rx_perr_ff  <= 1'b0;
    end else if (rx_state_ff == asx_pkg::RX_IDLE) begin
      // No frame is accepted before the init period ends
      if (tick && init_done && run && !ser_in_i) begin
        rx_state_ff <= asx_pkg::RX_START;
        rx_os_ff    <= 3'h1;
      end
    end else if (tick) begin
      rx_os_ff <= rx_os_ff + 3'h1;
      if (rx_sample) begin
        unique case (rx_state_ff)
          asx_pkg::RX_START: begin
            // A glitch shorter than half a bit is not a start
            rx_state_ff <= ser_in_i ? asx_pkg::RX_IDLE : asx_pkg::RX_DATA;
            rx_cnt_ff   <= 4'h0;
            rx_fe_ff    <= 1'b0;
            rx_perr_ff  <= 1'b0;
          end
          asx_pkg::RX_DATA: begin
            rx_sh_ff  <= {ser_in_i, rx_sh_ff[8:1]};
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == data_len - 4'h1) begin
              rx_stop_ff  <= 1'b0;
              rx_state_ff <= par_en ? asx_pkg::RX_PAR : asx_pkg::RX_STOP;
            end
          end
          asx_pkg::RX_PAR: begin
            rx_perr_ff  <= ((^rx_word) ^ ser_in_i) == rx_parity_or_ninth_ff;
            rx_state_ff <= asx_pkg::RX_STOP;
          end
          asx_pkg::RX_STOP: begin
            if (two_stop && !rx_stop_ff) begin
              rx_stop_ff <= 1'b1;
              rx_fe_ff   <= rx_fe_ff || !ser_in_i;
            end else begin
              rx_state_ff <= asx_pkg::RX_IDLE;
            end
          end
          asx_pkg::RX_IDLE: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Status flags and holding registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_empty_flag_ff <= 1'b1;
      tx_hold_ff       <= 8'h00;
    end else begin
      if (wr_hold) begin
        tx_hold_ff <= wdata_i;
      end
      if (tx_load) begin
        tx_empty_flag_ff <= 1'b1;
      end else if (wr_hold) begin
        tx_empty_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_full_flag_ff  <= 1'b0;
      rx_error_flag_ff <= 1'b0;
      err_armed_ff     <= 1'b0;
      rx_hold_ff       <= 8'h00;
    end else begin
      // Flags set only at the last stop bit; set wins over clear
      if (rx_done && !rx_bad) begin
        rx_full_flag_ff <= 1'b1;
        rx_hold_ff      <= rx_word[7:0];
      end else if (rd_hold) begin
        rx_full_flag_ff <= 1'b0;
      end
      if (rx_done && rx_bad) begin
        rx_error_flag_ff <= 1'b1;
      end else if (rd_hold && err_armed_ff) begin
        rx_error_flag_ff <= 1'b0;
      end
      if (rd_status && rx_error_flag_ff) begin
        err_armed_ff <= 1'b1;
      end else if (rd_hold || !rx_error_flag_ff) begin
        err_armed_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_one_ff           <= asx_pkg::MODE_ONE_RST;
      rate_ff               <= asx_pkg::RATE_RST;
      mode_two_ff           <= asx_pkg::MODE_TWO_RST;
      irq_level_ff          <= asx_pkg::IRQ_LEVEL_RST;
      tx_irq_enable_ff      <= 1'b0;
      rx_irq_enable_ff      <= 1'b0;
      tx_parity_or_ninth_ff <= asx_pkg::TX_PAR_RST;
      evt_en_ff             <= 3'h0;
    end else if (wr_i) begin
      unique case (addr_i)
        asx_pkg::OFF_MODE_ONE:  mode_one_ff <= wdata_i;
        asx_pkg::OFF_RATE:      rate_ff <= wdata_i;
        asx_pkg::OFF_MODE_TWO:  mode_two_ff <= wdata_i;
        asx_pkg::OFF_IRQ_LEVEL: irq_level_ff <= wdata_i[1:0];
        asx_pkg::OFF_EVT_EN:    evt_en_ff <= wdata_i[2:0];
        asx_pkg::OFF_STATUS: begin
          tx_irq_enable_ff      <= wdata_i[asx_pkg::ST_TX_IRQ_EN];
          rx_irq_enable_ff      <= wdata_i[asx_pkg::ST_RX_IRQ_EN];
          tx_parity_or_ninth_ff <= wdata_i[asx_pkg::ST_TX_PAR];
        end
        default: begin
        end
      endcase
    end
  end

  // Ninth received bit lands in the receive parity select bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_parity_or_ninth_ff <= 1'b0;
    end else if (rx_done && !rx_bad && ninth_en) begin
      rx_parity_or_ninth_ff <= rx_word[8];
    end else if (wr_i && (addr_i == asx_pkg::OFF_STATUS)) begin
      rx_parity_or_ninth_ff <= wdata_i[asx_pkg::ST_RX_PAR];
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign evt_set = {rx_done && rx_bad, rx_done && !rx_bad, tx_load};
  assign evt_clr = (wr_i && (addr_i == asx_pkg::OFF_EVT_CLR)) ? wdata_i[2:0] : 3'h0;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      evt_ff <= 3'h0;
    end else begin
      evt_ff <= (evt_ff & ~evt_clr) | evt_set;
    end
  end

  // Level line: one request for all three causes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (tx_empty_flag_ff && tx_irq_enable_ff) ||
                ((rx_full_flag_ff || rx_error_flag_ff) && rx_irq_enable_ff) ||
                (|(evt_ff & evt_en_ff));
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i || !rd_i) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (addr_i)
        asx_pkg::OFF_MODE_ONE:  rdata_ff <= mode_one_ff;
        asx_pkg::OFF_RATE:      rdata_ff <= rate_ff;
        asx_pkg::OFF_MODE_TWO:  rdata_ff <= mode_two_ff;
        asx_pkg::OFF_HOLD:      rdata_ff <= rx_hold_ff;
        asx_pkg::OFF_IRQ_LEVEL: rdata_ff <= {6'h00, irq_level_ff};
        asx_pkg::OFF_EVT_STAT:  rdata_ff <= {5'h00, evt_ff};
        asx_pkg::OFF_EVT_EN:    rdata_ff <= {5'h00, evt_en_ff};
        asx_pkg::OFF_STATUS:    rdata_ff <= {rx_full_flag_ff, rx_error_flag_ff, tx_empty_flag_ff,
                                             tx_irq_enable_ff, rx_irq_enable_ff, 1'b0,
                                             tx_parity_or_ninth_ff, rx_parity_or_ninth_ff};
        default:                rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata_o           = rdata_ff;
  assign ser_out_o         = ser_out_ff;
  assign serial_irq_line_o = irq_ff;
  assign irq_level_o       = irq_level_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  tx_load_empty_a: assert property (tx_load |=> tx_empty_flag_ff && !ser_out_o)
    else $error("empty flag or start bit missing after load");
  hold_write_a: assert property (wr_hold && !tx_load |=> !tx_empty_flag_ff)
    else $error("holding write did not clear empty flag");
  hold_read_a: assert property (rd_hold && !(rx_done && !rx_bad) |=> !rx_full_flag_ff)
    else $error("holding read did not clear full flag");
  good_frame_a: assert property (rx_done && !rx_bad |=> rx_full_flag_ff && rx_hold_ff == 8'($past(rx_word)))
    else $error("good frame not loaded");
  bad_frame_a: assert property (rx_done && rx_bad |=> rx_error_flag_ff && $stable(rx_hold_ff))
    else $error("bad frame loaded or error flag missing");
  full_rise_a: assert property ($rose(rx_full_flag_ff) |-> $past(rx_done))
    else $error("full flag rose outside stop bit");
  irq_tx_a: assert property (tx_empty_flag_ff && tx_irq_enable_ff |=> serial_irq_line_o)
    else $error("interrupt missing for empty flag");
  irq_quiet_a: assert property (!tx_empty_flag_ff && !rx_full_flag_ff && !rx_error_flag_ff && evt_ff == 3'h0
                                |=> !serial_irq_line_o)
    else $error("interrupt without cause");
  init_idle_a: assert property (!init_done |-> tx_state_ff == asx_pkg::TX_IDLE && rx_state_ff == asx_pkg::RX_IDLE)
    else $error("traffic before init period");
  err_clear_a: assert property (rd_status && rx_error_flag_ff ##1 !rd_hold && !rx_done
                                ##1 rd_hold && !rx_done |=> !rx_error_flag_ff)
    else $error("error flag not cleared by read pair");

  tx_frame_c: cover property (tx_load ##[1:300] tx_state_ff == asx_pkg::TX_STOP);
  rx_good_c: cover property (rx_done && !rx_bad);
  rx_overrun_c: cover property (rx_done && rx_full_flag_ff);

endmodule

/* File: asx_pkg.sv */
// Constants, register map and state types of the asynchronous serial block.
// Assumes one 100 MHz clock and byte-wide register access at the offsets below.
package asx_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFF_MODE_ONE   = 8'h20;
  localparam logic [7:0] OFF_RATE       = 8'h21;
  localparam logic [7:0] OFF_STATUS     = 8'h22;
  localparam logic [7:0] OFF_HOLD       = 8'h23;
  localparam logic [7:0] OFF_MODE_TWO   = 8'h24;
  localparam logic [7:0] OFF_EVT_STAT   = 8'h25;
  localparam logic [7:0] OFF_EVT_CLR    = 8'h26;
  localparam logic [7:0] OFF_EVT_EN     = 8'h27;
  localparam logic [7:0] OFF_IRQ_LEVEL  = 8'h7D;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MODE_ONE_PAR_EN   = 7;
  localparam int MODE_ONE_TWO_STOP = 6;
  localparam int MODE_ONE_MODE_LO  = 4;
  localparam int MODE_TWO_RUN      = 5;
  localparam int ST_RX_FULL        = 7;
  localparam int ST_RX_ERR         = 6;
  localparam int ST_TX_EMPTY       = 5;
  localparam int ST_TX_IRQ_EN      = 4;
  localparam int ST_RX_IRQ_EN      = 3;
  localparam int ST_TX_PAR         = 1;
  localparam int ST_RX_PAR         = 0;
  localparam int EVT_TX_EMPTY      = 0;
  localparam int EVT_RX_FULL       = 1;
  localparam int EVT_RX_ERR        = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] MODE_ONE_RST  = 8'h00;
  localparam logic [7:0] RATE_RST      = 8'h00;
  localparam logic [7:0] MODE_TWO_RST  = 8'h00;
  localparam logic [1:0] IRQ_LEVEL_RST = 2'h3;
  localparam logic       TX_PAR_RST    = 1'b1;

  // ************************************************************
  // Modes, lengths, counts
  // ************************************************************
  localparam logic [1:0] MODE0      = 2'h0;
  localparam logic [1:0] MODE1      = 2'h1;
  localparam logic [1:0] MODE3      = 2'h3;
  localparam logic [3:0] LEN_MODE0  = 4'h7;
  localparam logic [3:0] LEN_MODE1  = 4'h8;
  localparam logic [3:0] LEN_NINTH  = 4'h9;
  localparam logic [2:0] OS_LAST    = 3'h7;
  localparam logic [2:0] OS_MID     = 3'h4;
  localparam logic [3:0] INIT_TICKS = 4'hB;
  localparam logic [15:0] VEC_UPPER = 16'hFFF2;
  localparam logic [15:0] VEC_LOWER = 16'hFFF3;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } asx_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } asx_rx_state_t;

endpackage

/* File: asx_tick_gen.sv */
// Shift clock divider: one tick every div_i+1 clock cycles while running.
// Assumes div_i is held stable by software between frames.
`timescale 1ns/1ns
module asx_tick_gen (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       run_i,
  input  wire logic [7:0] div_i,
  output logic            tick_o
);

  logic [7:0] cnt_ff;
  logic       tick_ff;

  // ************************************************************
  // Divider
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i || !run_i) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else if (cnt_ff == div_i) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end

  assign tick_o = tick_ff;

endmodule

/* File: asx_node.sv */
// Remote serial node: sends frames on the receive line, captures transmitted ones.
// Assumes rate register 0, so one bit lasts 8 clocks.
`timescale 1ns/1ns
module asx_node (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  // Low start, n bits LSB first, stop within them, then idle high
  task automatic send(input logic [10:0] v, input int n);
    @(posedge clk_i);
    line_o <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (8) @(posedge clk_i);
      line_o <= (i == n) ? 1'b1 : v[i];
    end
  endtask
  // Sample mid-bit, LSB first; bounded wait for the start
  task automatic capture(input int n, output logic [10:0] v);
    int w;
    v = 11'h7FF;
    w = 0;
    while (line_i !== 1'b0 && w < 400) begin
      @(posedge clk_i);
      w++;
    end
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk_i);
      v[i] = line_i;
    end
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench of the serial block with a remote node model.
// Assumes rate 0; one frame format uses two stop bits.
`timescale 1ns/1ns
module tb_top;
  logic        clk_i = 1'b0;
  logic        reset_i, wr_s, rd_s, ser_in, ser_out, irq;
  logic [7:0]  addr, wdata, rdata, m, d;
  logic [1:0]  lvl;
  logic [10:0] got, v;
  logic [31:0] lfsr_ff = 32'h133BD8AF;
  logic        s;
  int          error_cnt = 0;
  int          checked = 0;
  logic [7:0]  cfgs [4] = '{8'h00, 8'h50, 8'h30, 8'h90};
  always #5 clk_i = ~clk_i;
  asx_uart i_asx_uart (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
    .rd_i(rd_s), .rdata_o(rdata), .ser_in_i(ser_in), .ser_out_o(ser_out), .serial_irq_line_o(irq),
    .irq_level_o(lvl));
  asx_node i_asx_node (.clk_i(clk_i), .line_i(ser_out), .line_o(ser_in));
  // ************************************************************
  // Expectations and bus tasks
  // ************************************************************
  function automatic int dbits(input logic [7:0] mc);
    return (mc[5:4] == asx_pkg::MODE0) ? 7 : 8;
  endfunction
  function automatic int flen(input logic [7:0] mc);
    return dbits(mc) + ((mc[7] || mc[5:4] == asx_pkg::MODE3) ? 1 : 0);
  endfunction
  // Data, then parity (0 odd, 1 even) or ninth bit, then stop ones
  function automatic logic [10:0] fbits(input logic [7:0] mc, input logic sel, input logic [7:0] dv);
    logic [10:0] r;
    r = {3'h7, dv};
    if (dbits(mc) == 7) r[7] = 1'b1;
    if (flen(mc) > dbits(mc)) r[dbits(mc)] = mc[7] ? ~(^dv ^ sel) : sel;
    return r;
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    addr <= a;
    wdata <= dv;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] mk, input logic [7:0] exp);
    logic [7:0] r;
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 r = rdata;
    @(posedge clk_i);
    chk(nm, r & mk, exp);
  endtask
  task automatic wrap_up;
    $display("Counts: checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well above the roughly 1300 cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    wrap_up;
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    reset_i = 1'b1; addr = 8'h00; wdata = 8'h00; wr_s = 1'b0; rd_s = 1'b0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk("level", lvl, 2'h3);
    wr(asx_pkg::OFF_IRQ_LEVEL, 8'h01);
    chk("level wr", lvl, 2'h1);
    rc("level rd", asx_pkg::OFF_IRQ_LEVEL, 8'hFF, 8'h01);
    rc("status rst", asx_pkg::OFF_STATUS, 8'hFF, 8'h22);
    rc("unmapped", 8'h30, 8'hFF, 8'h00);
    wr(asx_pkg::OFF_RATE, 8'h00);
    wr(asx_pkg::OFF_MODE_TWO, 8'h20);
    repeat (20) @(posedge clk_i); // Init period of 11 ticks must pass first
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      m = cfgs[c];
      s = lfsr_ff[0];
      d = lfsr_ff[15:8] & ((dbits(m) == 7) ? 8'h7F : 8'hFF);
      wr(asx_pkg::OFF_MODE_ONE, m);
      wr(asx_pkg::OFF_STATUS, {6'h00, s, s});
      fork
        i_asx_node.capture(flen(m) + 1 + int'(m[6]), got);
        wr(asx_pkg::OFF_HOLD, d);
      join
      chk("tx frame", got, fbits(m, s, d));
      v = fbits(m, s, d);
      if (m == 8'h30) v[8] = ~s;
      i_asx_node.send(v, flen(m) + 1 + int'(m[6]));
      repeat (4) @(posedge clk_i);
      rc("rx full", asx_pkg::OFF_STATUS, 8'hC1, {7'h40, (m == 8'h30) ? ~s : s});
      rc("rx data", asx_pkg::OFF_HOLD, 8'hFF, d);
      rc("full clr", asx_pkg::OFF_STATUS, 8'h80, 8'h00);
      $display("test mode config %0d done", c);
    end
    wr(asx_pkg::OFF_MODE_ONE, 8'h10);
    wr(asx_pkg::OFF_STATUS, 8'h10);
    wr(asx_pkg::OFF_HOLD, 8'h55);
    wr(asx_pkg::OFF_HOLD, 8'hAA);
    rc("tx busy", asx_pkg::OFF_STATUS, 8'h20, 8'h00);
    chk("irq busy", irq, 1'b0);
    repeat (120) @(posedge clk_i);
    chk("irq empty", irq, 1'b1);
    wr(asx_pkg::OFF_STATUS, 8'h00);
    repeat (100) @(posedge clk_i);
    rc("events", asx_pkg::OFF_EVT_STAT, 8'h03, 8'h03);
    wr(asx_pkg::OFF_EVT_EN, 8'h07);
    repeat (2) @(posedge clk_i);
    chk("irq event", irq, 1'b1);
    wr(asx_pkg::OFF_EVT_EN, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq masked", irq, 1'b0);
    wr(asx_pkg::OFF_EVT_CLR, 8'h07);
    rc("events clr", asx_pkg::OFF_EVT_STAT, 8'h07, 8'h00);
    $display("test transmit and events done");
    wr(asx_pkg::OFF_STATUS, 8'h08);
    i_asx_node.send({3'h7, 8'h3C}, 9);
    i_asx_node.send({3'h7, 8'hC3}, 9);
    repeat (4) @(posedge clk_i);
    chk("irq rx", irq, 1'b1);
    rc("overrun", asx_pkg::OFF_STATUS, 8'hC0, 8'hC0);
    rc("kept word", asx_pkg::OFF_HOLD, 8'hFF, 8'h3C);
    rc("err clr", asx_pkg::OFF_STATUS, 8'hC0, 8'h00);
    chk("irq clr", irq, 1'b0);
    wr(asx_pkg::OFF_MODE_ONE, 8'h90);
    wr(asx_pkg::OFF_STATUS, 8'h01);
    v = fbits(8'h90, 1'b1, 8'h5A);
    v[8] = ~v[8];
    i_asx_node.send(v, 10);
    repeat (4) @(posedge clk_i);
    rc("parity err", asx_pkg::OFF_STATUS, 8'hC0, 8'h40);
    $display("test receive errors done");
    wrap_up;
  end
endmodule
